// ### diag_pkg.sv
// Purpose: constants and types shared by the off-line diagnostic selector
// Assumes: 40 MHz board clock, Avalon-MM slave with 32-bit data
// Notes: register offsets are byte addresses, one aligned word each
// What this block does
// - diagnostic mode only if enable jumper open at a start, held until the next start
// - five jumpers form test number, inserted reads one
// - power-up, bus init or wake command starts test
// - both lamps off when a test starts
// - each clean pass toggles ready lamp, reruns test
// - error stops repeats, error lamp blinks code
// - test numbers map to their documented test kinds
// - blink: 3s on, pulses, 2s off, pulses, 2s off, repeat
`default_nettype none
package diag_pkg;

	localparam int unsigned CLK_HZ = 40000000;

	// register map
	localparam logic [7:0] ADDR_WAKE = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PASS = 8'h08;
	localparam logic [7:0] ADDR_ERROR = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	// jumper group layout and wake command bit
	localparam int JMP_ENABLE_BIT = 5;
	localparam int WAKE_CLEAR_BIT = 0;

	// status register fields
	localparam int ST_MODE = 0;
	localparam int ST_NUM_LO = 1;
	localparam int ST_RUN = 8;
	localparam int ST_FAIL = 9;
	localparam int ST_RDY = 10;
	localparam int ST_ERR = 11;
	localparam int ST_KIND_LO = 12;
	localparam int ST_UNIT = 15;

	// interrupt status and mask layout
	localparam int IRQ_W = 3;
	localparam int IRQ_START = 0;
	localparam int IRQ_PASS = 1;
	localparam int IRQ_ERROR = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// test numbers
	localparam logic [4:0] TEST_ENV = 5'h1F;
	localparam logic [4:0] TEST_FACT_HI = 5'h1E;
	localparam logic [4:0] TEST_FACT_LO = 5'h1C;
	localparam logic [4:0] TEST_RWSEQ = 5'h1B;
	localparam logic [4:0] TEST_LAMPADDR = 5'h1A;
	localparam logic [4:0] TEST_FLOPPY0 = 5'h19;
	localparam logic [4:0] TEST_FLOPPY1 = 5'h18;
	localparam logic [4:0] TEST_HARD0 = 5'h17;
	localparam logic [4:0] TEST_HARD1 = 5'h16;
	localparam logic [4:0] TEST_TAPE = 5'h15;

	typedef enum logic [2:0] {
		KIND_OTHER,
		KIND_ENV,
		KIND_FACTORY,
		KIND_RWSEQ,
		KIND_LAMPADDR,
		KIND_FLOPPY,
		KIND_HARD,
		KIND_TAPE
	} testKind_e;

	// blink timing
	localparam int unsigned LEAD_S = 3;
	localparam int unsigned GAP_S = 2;
	localparam int unsigned PULSE_MS = 250;
	localparam int unsigned LEAD_CYC = LEAD_S * CLK_HZ;
	localparam int unsigned GAP_CYC = GAP_S * CLK_HZ;
	localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);

endpackage
`default_nettype wire

// ### blink_if.sv
// Purpose: carries the error code to the blinker and the lamp level back
// Assumes: single clock domain
// Notes: lamp is a flop inside the blinker
`timescale 1ns/100ps
`default_nettype none
interface blink_if;
	logic enable;
	logic [7:0] code;
	logic lamp;
	modport ctrl (output enable, output code, input lamp);
	modport blinker (input enable, input code, output lamp);
endinterface
`default_nettype wire

// ### diag_blinker.sv
// Purpose: blinks an eight-bit error code as two hex digits of pulses
// Assumes: code is stable while enable is high
// Notes: dropping enable parks the sequence at its start with the lamp off
`timescale 1ns/100ps
`default_nettype none
module diag_blinker
	import diag_pkg::*;
#(
	parameter int unsigned LEAD_CYCLES = LEAD_CYC,
	parameter int unsigned GAP_CYCLES = GAP_CYC,
	parameter int unsigned PULSE_CYCLES = PULSE_CYC
)(
	input wire logic clk, // board clock
	input wire logic rst, // synchronous reset
	blink_if.blinker bl // code in, lamp out
);

	typedef enum logic [1:0] {B_LEAD, B_PON, B_POFF, B_GAP} blink_e;

	blink_e st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [3:0] left_r, left_nxt;
	logic digit_r, digit_nxt;
	logic lamp_r, lamp_nxt;

	assign bl.lamp = lamp_r;

	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 32'h1;
		left_nxt = left_r;
		digit_nxt = digit_r;
		case (st_r)
			B_LEAD:
				// count is one on the first lit cycle, so the lead lasts LEAD_CYCLES
				if (cnt_r == LEAD_CYCLES)
				begin
					cnt_nxt = 32'h0;
					digit_nxt = 1'b0;
					left_nxt = bl.code[7:4];
					// off time first, or the lead would swallow the first pulse
					st_nxt = (bl.code[7:4] == 4'h0) ? B_GAP : B_POFF;
				end
			B_PON:
				if (cnt_r == PULSE_CYCLES - 1)
				begin
					cnt_nxt = 32'h0;
					left_nxt = left_r - 4'h1;
					// the off time after the last pulse is folded into the gap
					st_nxt = (left_r == 4'h1) ? B_GAP : B_POFF;
				end
			B_POFF:
				if (cnt_r == PULSE_CYCLES - 1)
				begin
					cnt_nxt = 32'h0;
					st_nxt = B_PON;
				end
			default:
				if (cnt_r == GAP_CYCLES - 1)
				begin
					cnt_nxt = 32'h0;
					if (!digit_r)
					begin
						digit_nxt = 1'b1;
						left_nxt = bl.code[3:0];
						st_nxt = (bl.code[3:0] == 4'h0) ? B_GAP : B_PON;
					end
					else
					begin
						// lamp lights on this edge, so the lead count starts at one
						cnt_nxt = 32'h1;
						st_nxt = B_LEAD;
					end
				end
		endcase
		if (!bl.enable)
		begin
			st_nxt = B_LEAD;
			cnt_nxt = 32'h0;
			digit_nxt = 1'b0;
			left_nxt = 4'h0;
		end
		lamp_nxt = bl.enable && (st_nxt == B_LEAD || st_nxt == B_PON);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= B_LEAD;
			cnt_r <= 32'h0;
			left_r <= 4'h0;
			digit_r <= 1'b0;
			lamp_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			left_r <= left_nxt;
			digit_r <= digit_nxt;
			lamp_r <= lamp_nxt;
		end
	end

endmodule
`default_nettype wire

// ### offline_diag_selector.sv
// Purpose: selects an off-line diagnostic from jumpers, starts it, drives the lamps
// Assumes: board software runs the test and reports pass or error over the bus
// Notes: every start event re-samples the jumper group
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module offline_diag_selector
	import diag_pkg::*;
#(
	parameter int unsigned LEAD_CYCLES = LEAD_CYC,
	parameter int unsigned GAP_CYCLES = GAP_CYC,
	parameter int unsigned PULSE_CYCLES = PULSE_CYC
)(
	input wire logic clk, // board clock
	input wire logic rst, // synchronous reset, high
	input wire logic [5:0] diagSelectJumpers, // 1 = jumper inserted
	input wire logic busInitN, // host bus init, low active
	input wire logic [7:0] address, // byte address
	input wire logic read, // read request
	input wire logic write, // write request
	input wire logic [31:0] writedata, // write data
	input wire logic [3:0] byteenable, // write lanes
	output logic [31:0] readdata, // read data
	output logic waitrequest, // stall
	output logic irq, // level interrupt
	output logic readyLamp, // ready lamp
	output logic errorLamp, // error lamp
	output logic testStart, // pulse: run one pass
	output logic [4:0] testNumber, // latched test number
	output logic diagActive // diagnostic mode latched
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef enum logic [1:0] {S_IDLE, S_RUN, S_FAIL} diag_e;

	diag_e st_r, st_nxt;
	logic mode_r, mode_nxt;
	logic [4:0] num_r, num_nxt;
	logic rdy_r, rdy_nxt;
	logic [7:0] errCode_r, errCode_nxt;
	logic start_r, start_nxt;
	logic powerUp_r, powerUp_nxt;
	logic initPrev_r, initPrev_nxt;
	logic wait_r, wait_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [IRQ_W-1:0] irqStat_r, irqStat_nxt;
	logic [IRQ_W-1:0] irqMask_r, irqMask_nxt;
	logic irq_r, irq_nxt;
	logic errLamp_r;

	blink_if bl ();

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic req, take;
	logic wrWake, wrPass, wrError, wrMask, rdIrq;

	assign req = read || write;
	// one wait cycle: the request is seen, then taken on the next edge
	assign take = req && !wait_r;
	assign wrWake = take && write && byteenable[0] && address == ADDR_WAKE
		&& writedata[WAKE_CLEAR_BIT];
	assign wrPass = take && write && address == ADDR_PASS;
	assign wrError = take && write && byteenable[0] && address == ADDR_ERROR;
	assign wrMask = take && write && byteenable[0] && address == ADDR_IRQ_MASK;
	assign rdIrq = take && read && address == ADDR_IRQ_STAT;

	////////////////////////////////////////////////////////////////////////////
	// test classification

	testKind_e kind;
	logic unit;

	always_comb
	begin
		kind = KIND_OTHER;
		unit = 1'b0;
		case (num_r)
			TEST_ENV: kind = KIND_ENV;
			TEST_RWSEQ: kind = KIND_RWSEQ;
			TEST_LAMPADDR: kind = KIND_LAMPADDR;
			TEST_FLOPPY0: kind = KIND_FLOPPY;
			TEST_FLOPPY1:
			begin
				kind = KIND_FLOPPY;
				unit = 1'b1;
			end
			TEST_HARD0: kind = KIND_HARD;
			TEST_HARD1:
			begin
				kind = KIND_HARD;
				unit = 1'b1;
			end
			TEST_TAPE: kind = KIND_TAPE;
			default:
				if (num_r >= TEST_FACT_LO && num_r <= TEST_FACT_HI)
					kind = KIND_FACTORY;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// status word

	logic [31:0] status;

	always_comb
	begin
		status = 32'h0;
		status[ST_MODE] = mode_r;
		status[ST_NUM_LO +: 5] = num_r;
		status[ST_RUN] = (st_r == S_RUN);
		status[ST_FAIL] = (st_r == S_FAIL);
		status[ST_RDY] = rdy_r;
		status[ST_ERR] = errLamp_r;
		status[ST_KIND_LO +: 3] = kind;
		status[ST_UNIT] = unit;
	end

	////////////////////////////////////////////////////////////////////////////
	// diagnostic sequencing

	logic startEv, initFall, stopEv, passEv;

	assign initFall = initPrev_r && !busInitN;
	assign startEv = powerUp_r || initFall || wrWake;
	assign passEv = wrPass && st_r == S_RUN;
	assign stopEv = wrError && st_r == S_RUN;

	always_comb
	begin
		st_nxt = st_r;
		mode_nxt = mode_r;
		num_nxt = num_r;
		rdy_nxt = rdy_r;
		errCode_nxt = errCode_r;
		start_nxt = 1'b0;
		powerUp_nxt = 1'b0;
		initPrev_nxt = busInitN;
		if (startEv)
		begin
			// a later start also ends a blinking error code
			mode_nxt = !diagSelectJumpers[JMP_ENABLE_BIT];
			num_nxt = diagSelectJumpers[4:0];
			rdy_nxt = 1'b0;
			errCode_nxt = 8'h00;
			if (!diagSelectJumpers[JMP_ENABLE_BIT])
			begin
				st_nxt = S_RUN;
				start_nxt = 1'b1;
			end
			else
			begin
				st_nxt = S_IDLE;
			end
		end
		else if (stopEv)
		begin
			st_nxt = S_FAIL;
			rdy_nxt = 1'b0;
			errCode_nxt = writedata[7:0];
		end
		else if (passEv)
		begin
			rdy_nxt = !rdy_r;
			start_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= S_IDLE;
			mode_r <= 1'b0;
			num_r <= 5'h00;
			rdy_r <= 1'b0;
			errCode_r <= 8'h00;
			start_r <= 1'b0;
			// power-up counts as a start event on the first edge after reset
			powerUp_r <= 1'b1;
			initPrev_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			num_r <= num_nxt;
			rdy_r <= rdy_nxt;
			errCode_r <= errCode_nxt;
			start_r <= start_nxt;
			powerUp_r <= powerUp_nxt;
			initPrev_r <= initPrev_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// error lamp blinker

	assign bl.enable = (st_r == S_FAIL);
	assign bl.code = errCode_r;
	assign errLamp_r = bl.lamp;

	diag_blinker #(
		.LEAD_CYCLES(LEAD_CYCLES),
		.GAP_CYCLES(GAP_CYCLES),
		.PULSE_CYCLES(PULSE_CYCLES)
	) u_blinker (
		.clk(clk),
		.rst(rst),
		.bl(bl)
	);

	////////////////////////////////////////////////////////////////////////////
	// register slave and interrupts

	always_comb
	begin
		wait_nxt = !(req && wait_r);
		rd_nxt = rd_r;
		if (req && wait_r && read)
		begin
			// unmapped and write-only addresses read as zero
			if (address == ADDR_STATUS)
				rd_nxt = status;
			else if (address == ADDR_ERROR)
				rd_nxt = {24'h000000, errCode_r};
			else if (address == ADDR_IRQ_STAT)
				rd_nxt = {29'h00000000, irqStat_r};
			else if (address == ADDR_IRQ_MASK)
				rd_nxt = {29'h00000000, irqMask_r};
			else
				rd_nxt = 32'h0;
		end
		irqMask_nxt = wrMask ? writedata[IRQ_W-1:0] : irqMask_r;
		// clear on read first, so an event in the same cycle survives
		irqStat_nxt = rdIrq ? {IRQ_W{1'b0}} : irqStat_r;
		if (start_nxt && startEv)
			irqStat_nxt[IRQ_START] = 1'b1;
		if (passEv && !startEv)
			irqStat_nxt[IRQ_PASS] = 1'b1;
		if (stopEv && !startEv)
			irqStat_nxt[IRQ_ERROR] = 1'b1;
		irq_nxt = |(irqStat_nxt & irqMask_nxt);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wait_r <= 1'b1;
			rd_r <= 32'h0;
			irqStat_r <= {IRQ_W{1'b0}};
			irqMask_r <= IRQ_MASK_RESET;
			irq_r <= 1'b0;
		end
		else
		begin
			wait_r <= wait_nxt;
			rd_r <= rd_nxt;
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
			irq_r <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign readdata = rd_r;
	assign waitrequest = wait_r;
	assign irq = irq_r;
	assign readyLamp = rdy_r;
	assign errorLamp = errLamp_r;
	assign testStart = start_r;
	assign testNumber = num_r;
	assign diagActive = mode_r;

endmodule
`default_nettype wire

// ### offline_diag_selector_monitor.sv
// Purpose: port-level checks of the diagnostic selector
// Assumes: one clock, synchronous active-high reset
// Notes: blink widths come from the bound parameters
`timescale 1ns/100ps
`default_nettype none
module offline_diag_selector_monitor
#(
	parameter int unsigned LEAD_CYCLES = 8,
	parameter int unsigned PULSE_CYCLES = 3
)(
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic read, // bus read
	input wire logic write, // bus write
	input wire logic waitrequest, // bus stall
	input wire logic testStart, // pass pulse
	input wire logic diagActive, // mode
	input wire logic readyLamp, // ready lamp
	input wire logic errorLamp // error lamp
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
// length of the current lit stretch of the error lamp
logic [31:0] onLen_r;
logic [31:0] onLen_nxt;
always_comb
begin
	onLen_nxt = errorLamp ? onLen_r + 32'h1 : 32'h0;
end
always_ff @(posedge clk)
begin
	onLen_r <= rst ? 32'h0 : onLen_nxt;
end
////////////////////////////////////////////////////////////////////////////////
sequence reqSeen;
	(read || write) && waitrequest;
endsequence
sequence answered;
	!waitrequest ##1 waitrequest;
endsequence
bus_answer_a: assert property (reqSeen |=> answered)
	else $error("bus answer not one wait");
bus_idle_a: assert property (!read && !write && waitrequest |=> waitrequest)
	else $error("bus answer without request");
start_pulse_a: assert property (testStart |=> !testStart)
	else $error("start pulse too long");
start_mode_a: assert property (testStart |-> diagActive)
	else $error("start outside diagnostic mode");
ready_rise_a: assert property ($rose(readyLamp) |-> testStart)
	else $error("ready lamp lit without pass");
start_clears_a: assert property (testStart |=> !errorLamp)
	else $error("error lamp lit after start");
idle_dark_a: assert property (!diagActive && $past(diagActive) == 1'b0 |-> !readyLamp && !errorLamp)
	else $error("lamp lit in normal mode");
blink_width_a: assert property ($fell(errorLamp) |-> onLen_r == LEAD_CYCLES || onLen_r == PULSE_CYCLES)
	else $error("error lamp on time wrong");
fail_dark_a: assert property (errorLamp |-> !readyLamp)
	else $error("ready lamp lit while failing");
endmodule
`default_nettype wire

// ### test_offline_diag_selector.sv
// Purpose: self-checking bench of the diagnostic selector
// Assumes: blink counts shrunk to 8, 6 and 3 cycles
// Notes: starts come from power-up, bus init and the wake register
`timescale 1ns/100ps
`default_nettype none
module test_offline_diag_selector import diag_pkg::*;;
logic clk, rst, busInitN, read, write, waitrequest, irq, readyLamp, errorLamp;
logic testStart, diagActive;
logic [5:0] jumpers;
logic [7:0] address;
logic [31:0] writedata, readdata, q;
logic [4:0] testNumber;
int failures, num_checks, cyc;
offline_diag_selector #(.LEAD_CYCLES(8), .GAP_CYCLES(6), .PULSE_CYCLES(3)) uut (
	.clk(clk), .rst(rst), .diagSelectJumpers(jumpers), .busInitN(busInitN),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
	.readyLamp(readyLamp), .errorLamp(errorLamp), .testStart(testStart),
	.testNumber(testNumber), .diagActive(diagActive));
////////////////////////////////////////////////////////////////////////////////
task stop_test;
	$display("checks %0d failures %0d", num_checks, failures);
	if (failures == 0 && num_checks > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
	num_checks++;
	if (got !== exp)
	begin
		failures++;
		$display("ERROR %s expected %h seen %h", nm, exp, got);
	end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	@(posedge clk);
	address <= a;
	writedata <= d;
	write <= w;
	read <= !w;
	n = 0;
	do
	begin
		@(posedge clk);
		n++;
	end
	while (waitrequest !== 1'b0 && n < 20);
	check("answer", n < 20, 1);
	q = readdata;
	read <= 1'b0;
	write <= 1'b0;
endtask
// the pulse stands in the cycle after the edge that takes its cause,
// so look from just after the current edge and over the next three
task waitStart(input logic exp);
	logic seen;
	seen = 0;
	repeat (4)
	begin
		#1 seen |= testStart;
		@(posedge clk);
	end
	check("testStart", seen, exp);
endtask
function automatic logic [2:0] kindOf(input logic [4:0] n);
	case (n)
	5'h1F: return 3'h1;
	5'h1E, 5'h1D, 5'h1C: return 3'h2;
	5'h1B: return 3'h3;
	5'h1A: return 3'h4;
	5'h19, 5'h18: return 3'h5;
	5'h17, 5'h16: return 3'h6;
	5'h15: return 3'h7;
	default: return 3'h0;
	endcase
endfunction
// lamp for code 21: lead 8, off 3, on 3, off 3, on 3, gap 6, on 3, gap 6
function automatic logic pat(input int t);
	int u;
	u = t % 35;
	if (u < 8)
		return 1;
	if (u < 20)
		return (u - 8) % 6 >= 3;
	if (u < 26)
		return 0;
	return u < 29;
endfunction
////////////////////////////////////////////////////////////////////////////////
task t_powerup;
	waitStart(1);
	check("lamps", {readyLamp, errorLamp}, 0);
	check("diagActive", diagActive, 1);
	check("testNumber", testNumber, 5'h1F);
endtask
task t_passes;
	bus(1, ADDR_PASS, 0);
	waitStart(1);
	check("ready", readyLamp, 1);
	bus(1, ADDR_PASS, 0);
	waitStart(1);
	check("ready", readyLamp, 0);
endtask
task t_kinds;
	logic [4:0] n;
	for (int i = 31; i >= 20; i--)
	begin
		n = i[4:0];
		jumpers <= {1'b0, n};
		bus(1, ADDR_WAKE, 1);
		waitStart(1);
		bus(0, ADDR_STATUS, 0);
		check("status", q, {n == 5'h18 || n == 5'h16, kindOf(n), 4'h1, 2'h0, n, 1'b1});
	end
	jumpers <= 6'h0A;
	repeat (3) @(posedge clk);
	check("held", testNumber, 5'h14);
endtask
task t_init;
	jumpers <= 6'h37;
	busInitN <= 1'b0;
	waitStart(0);
	check("diagActive", {diagActive, testNumber}, 6'h17);
	busInitN <= 1'b1;
	jumpers <= 6'h15;
	@(posedge clk);
	busInitN <= 1'b0;
	waitStart(1);
	check("testNumber", testNumber, 5'h15);
	busInitN <= 1'b1;
endtask
task t_irq;
	bus(0, ADDR_IRQ_STAT, 0);
	bus(1, ADDR_IRQ_MASK, 2);
	bus(1, ADDR_PASS, 0);
	waitStart(1);
	check("irq", irq, 1);
	bus(0, ADDR_IRQ_STAT, 0);
	check("irqStat", q, 2);
	repeat (2) @(posedge clk);
	#1 check("irq", irq, 0);
	bus(1, ADDR_WAKE, 1);
	waitStart(1);
	check("irq", irq, 0);
	bus(0, 8'hFC, 0);
	check("unmapped", q, 0);
endtask
task t_error;
	bus(1, ADDR_ERROR, 32'h21);
	// lamp lights one edge after the error is taken; the refused pass and
	// the read-back leave the first sample at step 6 of the blink
	bus(1, ADDR_PASS, 0);
	bus(0, ADDR_ERROR, 0);
	check("code", q, 32'h21);
	for (int t = 6; t < 46; t++)
	begin
		@(posedge clk);
		#1 check("errorLamp", errorLamp, pat(t));
		check("ready", readyLamp, 0);
	end
	bus(1, ADDR_WAKE, 1);
	waitStart(1);
	check("errorLamp", errorLamp, 0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	clk = 0;
	forever #12.5 clk = ~clk;
end
always @(posedge clk)
begin
	cyc++;
	if (cyc == 3000)
	begin
		failures++;
		stop_test;
	end
end
initial
begin
	rst = 1;
	busInitN = 1;
	read = 0;
	write = 0;
	address = 0;
	writedata = 0;
	jumpers = 6'h1F;
	repeat (3) @(posedge clk);
	rst <= 0;
	t_powerup;
	t_passes;
	t_kinds;
	t_init;
	t_irq;
	t_error;
	stop_test;
end
endmodule
bind offline_diag_selector offline_diag_selector_monitor #(
	.LEAD_CYCLES(LEAD_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) mon (
	.clk(clk), .rst(rst), .read(read), .write(write), .waitrequest(waitrequest),
	.testStart(testStart), .diagActive(diagActive), .readyLamp(readyLamp),
	.errorLamp(errorLamp));
`default_nettype wire
